// ---- design/axi_lite_regs.sv ----
`default_nettype none
module axi_lite_regs (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic [sub_timing_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [sub_timing_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output logic                                   wrEn,
  output logic [5:0]                             wrIdx,
  output logic [7:0]                             wrData,
  output logic [5:0]                             rdIdx,
  input  wire logic [7:0]                        rdData
);
  typedef struct packed {
    logic       awRdy;
    logic       wRdy;
    logic       arRdy;
    logic       awHeld;
    logic       wHeld;
    logic [5:0] idx;
    logic [7:0] data;
    logic       lane0;
    logic       wrEn;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } axi_s;

  axi_s q;
  axi_s d;

  assign rdIdx = s_axi_araddr[7:2];

  always_comb
  begin
    d      = q;
    d.wrEn = 1'b0;
    if (s_axi_awvalid && q.awRdy)
    begin
      d.awHeld = 1'b1;
      d.idx    = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && q.wRdy)
    begin
      d.wHeld = 1'b1;
      d.data  = s_axi_wdata[7:0];
      d.lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    // a write lacking byte lane zero is answered but changes nothing
    if (q.awHeld && q.wHeld && !q.bvalid)
    begin
      d.wrEn   = q.lane0 && sub_timing_pkg::isMapped(q.idx);
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = sub_timing_pkg::isMapped(q.idx) ?
                 sub_timing_pkg::RESP_OKAY : sub_timing_pkg::RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arRdy)
    begin
      d.rvalid = 1'b1;
      d.rdata  = sub_timing_pkg::isMapped(rdIdx) ? rdData : 8'h00;
      d.rresp  = sub_timing_pkg::isMapped(rdIdx) ?
                 sub_timing_pkg::RESP_OKAY : sub_timing_pkg::RESP_SLVERR;
    end
    d.awRdy = !d.awHeld && !d.bvalid;
    d.wRdy  = !d.wHeld && !d.bvalid;
    d.arRdy = !d.rvalid;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign s_axi_awready = q.awRdy;
  assign s_axi_wready  = q.wRdy;
  assign s_axi_arready = q.arRdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = {24'h000000, q.rdata};
  assign wrEn          = q.wrEn;
  assign wrIdx         = q.idx;
  assign wrData        = q.data;

  a_bresp_hold: assert property (@(posedge clk_sys) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule : axi_lite_regs
`default_nettype wire

// ---- design/pin_sync.sv ----
`default_nettype none
module pin_sync (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] pinIn,
  output logic      [1:0] pinOut
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] held;
  } sync_s;

  sync_s q;
  sync_s d;

  // stage one feeds stage two only; a change counts once two and three agree
  always_comb
  begin
    d      = q;
    d.s1   = pinIn;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.held = (q.s2 & q.s3) | (q.held & (q.s2 | q.s3));
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign pinOut = q.held;
endmodule : pin_sync
`default_nettype wire

// ---- design/sub_timing_pkg.sv ----
`default_nettype none
package sub_timing_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [5:0]  REG_MODE     = 6'h05;
  localparam logic [5:0]  REG_POS_LO   = 6'h06;
  localparam logic [5:0]  REG_POS_HI   = 6'h07;
  localparam logic [5:0]  REG_PKT      = 6'h08;
  localparam logic [5:0]  REG_FRAME    = 6'h09;
  localparam logic [5:0]  REG_ADJ      = 6'h0a;
  localparam int          MODE_EN_BIT  = 6;
  localparam int          MODE_SEL_HI  = 5;
  localparam int          MODE_SEL_LO  = 4;
  localparam int          MODE_RD_BIT  = 3;
  localparam logic [1:0]  MODE_MAX     = 2'h3;
  localparam logic [1:0]  MODE_TGT     = 2'h2;
  localparam logic [1:0]  MODE_INIT    = 2'h1;
  localparam int          BYTE_LO_HI   = 7;
  localparam int          BYTE_LO_LO   = 3;
  localparam int          FI_EVERY_BIT = 5;
  localparam int          FI_FRAME_HI  = 4;
  localparam int          FI_FRAME_LO  = 1;
  localparam int          FI_PKT8_BIT  = 0;
  localparam int          ADJ_DIR_BIT  = 3;
  localparam int          ADJ_AMT_HI   = 2;
  localparam logic [8:0]  BIT_LAST     = 9'h11f;
  localparam logic [9:0]  BIT_COUNT    = 10'h120;
  localparam logic [8:0]  PKT_LAST     = 9'h10f;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  function automatic logic isMapped(input logic [5:0] idx);
    isMapped = (idx >= REG_MODE) && (idx <= REG_ADJ);
  endfunction : isMapped
endpackage : sub_timing_pkg
`default_nettype wire

// ---- design/subchannel_timing_interrupt.sv ----
// How it works
// - read select 1 shows live bit position
// - read select 0 shows position before sync
// - target byte from bits 3..8, low bits ignored
// - byte compared only while block-synchronised
// - interrupt fires entering the matching byte
// - packet low byte, bit 8 in frame register
// - init mode write loads packet counter
// - target mode write sets target packet
// - every-packet bit skips packet comparison
// - frame register bits 4..1 read frame count
// - init mode write preloads frame counter
// - frame counter wraps to zero after maximum
// - maximum mode write sets frame wrap value
// - target mode write sets target frame
// - interrupt needs packet, byte and frame match
// - two-bit mode field steers shared addresses
// - interrupt works only while enable set
// - adjust shifts bit timing up to seven
`default_nettype none
module subchannel_timing_interrupt (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              subBitClk,
  input  wire logic                              subBlockSync,
  output logic                                   subTimingIrq,
  input  wire logic [sub_timing_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [sub_timing_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);
  typedef struct packed {
    logic [8:0] livePos;
    logic [8:0] prePos;
    logic [8:0] pktCount;
    logic [3:0] frameCount;
    logic [3:0] frameWrap;
    logic [5:0] tgtByte;
    logic [8:0] tgtPacket;
    logic [3:0] tgtFrame;
    logic       everyPacket;
    logic       irqEnable;
    logic [1:0] writeMode;
    logic       readSelect;
    logic       bitPrev;
    logic       syncPrev;
    logic       irq;
  } timing_s;

  timing_s q;
  timing_s d;

  logic [1:0] pinsLvl;
  logic       bitLvl;
  logic       syncLvl;
  logic       bitTick;
  logic       wrEn;
  logic [5:0] wrIdx;
  logic [7:0] wrData;
  logic [5:0] rdIdx;
  logic [7:0] rdData;
  logic [2:0] adjAmt;
  logic [9:0] adjUp;
  logic [9:0] adjDown;
  logic [8:0] adjPos;
  logic       modeTgt;
  logic       modeInit;
  logic       modeMax;
  logic [8:0] shownPos;

  pin_sync u_pins (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   ({subBlockSync, subBitClk}),
    .pinOut  (pinsLvl)
  );

  axi_lite_regs u_regs (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrIdx         (wrIdx),
    .wrData        (wrData),
    .rdIdx         (rdIdx),
    .rdData        (rdData)
  );

  assign bitLvl  = pinsLvl[0];
  assign syncLvl = pinsLvl[1];
  // one tick per regenerated data bit, on its rising edge
  assign bitTick = bitLvl && !q.bitPrev;

  assign modeTgt  = (q.writeMode == sub_timing_pkg::MODE_TGT);
  assign modeInit = (q.writeMode == sub_timing_pkg::MODE_INIT);
  assign modeMax  = (q.writeMode == sub_timing_pkg::MODE_MAX);

  // adjustment wraps inside the packet; no carry into the packet counter
  assign adjAmt  = wrData[sub_timing_pkg::ADJ_AMT_HI:0];
  assign adjUp   = {1'b0, q.livePos} + {7'h00, adjAmt};
  assign adjDown = {1'b0, q.livePos} + sub_timing_pkg::BIT_COUNT - {7'h00, adjAmt};
  always_comb
  begin
    adjPos = q.livePos;
    if (wrData[sub_timing_pkg::ADJ_DIR_BIT])
    begin
      if (adjUp >= sub_timing_pkg::BIT_COUNT)
        adjPos = 9'(adjUp - sub_timing_pkg::BIT_COUNT);
      else
        adjPos = adjUp[8:0];
    end
    else
    begin
      if (adjDown >= sub_timing_pkg::BIT_COUNT)
        adjPos = 9'(adjDown - sub_timing_pkg::BIT_COUNT);
      else
        adjPos = adjDown[8:0];
    end
  end

  assign shownPos = q.readSelect ? q.livePos : q.prePos;

  always_comb
  begin
    rdData = 8'h00;
    unique case (rdIdx)
      sub_timing_pkg::REG_MODE:
        rdData = {1'b0, q.irqEnable, q.writeMode, q.readSelect, 3'h0};
      sub_timing_pkg::REG_POS_LO:
        rdData = shownPos[7:0];
      sub_timing_pkg::REG_POS_HI:
        rdData = {7'h00, shownPos[8]};
      sub_timing_pkg::REG_PKT:
        rdData = q.pktCount[7:0];
      sub_timing_pkg::REG_FRAME:
        rdData = {3'h0, q.frameCount, q.pktCount[8]};
      default:
        rdData = 8'h00;
    endcase
  end

  always_comb
  begin
    d          = q;
    d.irq      = 1'b0;
    d.bitPrev  = bitLvl;
    d.syncPrev = syncLvl;
    // catch the position on the cycle before sync takes hold
    if (syncLvl && !q.syncPrev)
      d.prePos = q.livePos;
    if (bitTick)
    begin
      if (q.livePos == sub_timing_pkg::BIT_LAST)
      begin
        d.livePos = 9'h000;
        if (q.pktCount == sub_timing_pkg::PKT_LAST)
        begin
          d.pktCount = 9'h000;
          if (q.frameCount == q.frameWrap)
            d.frameCount = 4'h0;
          else
            d.frameCount = q.frameCount + 4'h1;
        end
        else
          d.pktCount = q.pktCount + 9'h001;
      end
      else
        d.livePos = q.livePos + 9'h001;
    end
    if (wrEn)
    begin
      unique case (wrIdx)
        sub_timing_pkg::REG_MODE:
        begin
          d.irqEnable  = wrData[sub_timing_pkg::MODE_EN_BIT];
          d.writeMode  = wrData[sub_timing_pkg::MODE_SEL_HI:sub_timing_pkg::MODE_SEL_LO];
          d.readSelect = wrData[sub_timing_pkg::MODE_RD_BIT];
        end
        sub_timing_pkg::REG_POS_LO:
        begin
          if (modeTgt)
            d.tgtByte[4:0] = wrData[sub_timing_pkg::BYTE_LO_HI:sub_timing_pkg::BYTE_LO_LO];
        end
        sub_timing_pkg::REG_POS_HI:
        begin
          if (modeTgt)
            d.tgtByte[5] = wrData[0];
        end
        sub_timing_pkg::REG_PKT:
        begin
          if (modeInit)
            d.pktCount[7:0] = wrData;
          else if (modeTgt)
            d.tgtPacket[7:0] = wrData;
        end
        sub_timing_pkg::REG_FRAME:
        begin
          if (modeInit)
          begin
            d.pktCount[8] = wrData[sub_timing_pkg::FI_PKT8_BIT];
            d.frameCount  = wrData[sub_timing_pkg::FI_FRAME_HI:sub_timing_pkg::FI_FRAME_LO];
          end
          else if (modeTgt)
          begin
            d.tgtPacket[8] = wrData[sub_timing_pkg::FI_PKT8_BIT];
            d.everyPacket  = wrData[sub_timing_pkg::FI_EVERY_BIT];
            d.tgtFrame     = wrData[sub_timing_pkg::FI_FRAME_HI:sub_timing_pkg::FI_FRAME_LO];
          end
          else if (modeMax)
            d.frameWrap = wrData[sub_timing_pkg::FI_FRAME_HI:sub_timing_pkg::FI_FRAME_LO];
        end
        sub_timing_pkg::REG_ADJ:
          d.livePos = adjPos;
        default:
          d.livePos = d.livePos;
      endcase
    end
    // compare against the new values so the pulse lands on the byte's first bit
    d.irq = bitTick && q.irqEnable && syncLvl
            && (d.livePos[2:0] == 3'h0) && (d.livePos[8:3] == q.tgtByte)
            && (q.everyPacket || (d.pktCount == q.tgtPacket))
            && (d.frameCount == q.tgtFrame);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign subTimingIrq = q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_irq_needs_enable: assert property (
    subTimingIrq |-> $past(q.irqEnable) && $past(syncLvl))
    else $error("timing interrupt without enable or sync");

  a_irq_byte_start: assert property (
    subTimingIrq |-> q.livePos[2:0] == 3'h0 && q.livePos[8:3] == q.tgtByte)
    else $error("timing interrupt away from target byte start");

  a_irq_all_match: assert property (
    subTimingIrq |-> q.frameCount == q.tgtFrame
                     && (q.everyPacket || q.pktCount == q.tgtPacket))
    else $error("timing interrupt without packet and frame match");

  a_irq_on_tick: assert property (
    subTimingIrq |-> $past(bitTick) && !$past(subTimingIrq))
    else $error("timing interrupt not tied to one bit tick");

  a_pos_in_packet: assert property (
    q.livePos <= sub_timing_pkg::BIT_LAST)
    else $error("bit position outside the packet");

  a_bit_advance: assert property (
    bitTick && !wrEn && q.livePos != sub_timing_pkg::BIT_LAST
    |=> q.livePos == $past(q.livePos) + 9'h001)
    else $error("bit position failed to advance");

  a_frame_wrap: assert property (
    bitTick && !wrEn && q.livePos == sub_timing_pkg::BIT_LAST
    && q.pktCount == sub_timing_pkg::PKT_LAST && q.frameCount == q.frameWrap
    |=> q.frameCount == 4'h0 && q.pktCount == 9'h000)
    else $error("frame counter did not wrap at maximum");

  a_wrap_mode_gate: assert property (
    !(wrEn && wrIdx == sub_timing_pkg::REG_FRAME && modeMax) |=> $stable(q.frameWrap))
    else $error("frame wrap value changed outside maximum mode");

  a_presync_capture: assert property (
    syncLvl && !q.syncPrev |=> q.prePos == $past(q.livePos))
    else $error("position before sync not captured");

  a_packet_load: assert property (
    wrEn && wrIdx == sub_timing_pkg::REG_PKT && modeInit
    |=> q.pktCount[7:0] == $past(wrData))
    else $error("packet counter not loaded in init mode");

  a_target_gate: assert property (
    !(wrEn && modeTgt) |=> $stable(q.tgtByte) && $stable(q.tgtPacket)
                           && $stable(q.tgtFrame) && $stable(q.everyPacket))
    else $error("interrupt target changed outside target mode");

  a_init_gate: assert property (
    !(wrEn && modeInit) && !bitTick
    |=> $stable(q.pktCount) && $stable(q.frameCount))
    else $error("packet or frame counter moved without tick or load");

  a_packet_advance: assert property (
    bitTick && !wrEn && q.livePos == sub_timing_pkg::BIT_LAST
    && q.pktCount != sub_timing_pkg::PKT_LAST
    |=> q.livePos == 9'h000 && q.pktCount == $past(q.pktCount) + 9'h001)
    else $error("packet counter failed to advance at packet end");

  a_frame_advance: assert property (
    bitTick && !wrEn && q.livePos == sub_timing_pkg::BIT_LAST
    && q.pktCount == sub_timing_pkg::PKT_LAST && q.frameCount != q.frameWrap
    |=> q.frameCount == $past(q.frameCount) + 4'h1)
    else $error("frame counter failed to advance at frame end");

  a_byte_target: assert property (
    wrEn && wrIdx == sub_timing_pkg::REG_POS_LO && modeTgt
    |=> q.tgtByte[4:0]
        == $past(wrData[sub_timing_pkg::BYTE_LO_HI:sub_timing_pkg::BYTE_LO_LO]))
    else $error("target byte not taken from the position register");

  a_wrap_load: assert property (
    wrEn && wrIdx == sub_timing_pkg::REG_FRAME && modeMax
    |=> q.frameWrap == $past(wrData[sub_timing_pkg::FI_FRAME_HI:sub_timing_pkg::FI_FRAME_LO]))
    else $error("frame wrap value not loaded in maximum mode");

  a_frame_readback: assert property (
    rdIdx == sub_timing_pkg::REG_FRAME |-> q.frameCount
        == rdData[sub_timing_pkg::FI_FRAME_HI:sub_timing_pkg::FI_FRAME_LO])
    else $error("frame register does not show the frame counter");
endmodule : subchannel_timing_interrupt
`default_nettype wire

// ---- tb/subchannel_timing_interrupt_tb_top.sv ----
`default_nettype none
module subchannel_timing_interrupt_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys;
  logic        rst;
  logic        bitClk;
  logic        blkSync;
  logic        irq;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  int          errors;
  int          samples_checked;
  int          cycles;
  int          irqCnt;
  int          seed;
  logic [8:0]  pos;
  logic [8:0]  pkt;
  logic [3:0]  frm;
  logic [3:0]  wrapVal;
  logic [8:0]  preSync;
  logic [31:0] rd;
  logic [1:0]  resp;
  logic [3:0]  adj;

  subchannel_timing_interrupt subchannel_timing_interrupt_inst (
    .clk_sys(clk_sys), .rst(rst), .subBitClk(bitClk), .subBlockSync(blkSync),
    .subTimingIrq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  initial
  begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("counts: checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // whole run needs about 4000 cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (irq === 1'h1)
      irqCnt <= irqCnt + 1;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic axiWr(input logic [7:0] a, input logic [7:0] d);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!(awDone && wDone))
    begin
      @(posedge clk_sys);
      if (!awDone && awready === 1'h1)
      begin
        awDone = 1;
        awvalid <= 1'h0;
      end
      if (!wDone && wready === 1'h1)
      begin
        wDone = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk_sys); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_sys); while (rvalid !== 1'h1);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : axiRd

  task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
    axiRd(a);
    check(name, rd, exp);
    check({name, "_resp"}, {30'h0, resp}, {30'h0, sub_timing_pkg::RESP_OKAY});
  endtask : rdChk

  // model follows every bit the pin delivers
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      bitClk <= 1'h1;
      repeat (4) @(posedge clk_sys);
      bitClk <= 1'h0;
      repeat (4) @(posedge clk_sys);
      if (pos != sub_timing_pkg::BIT_LAST)
        pos++;
      else
      begin
        pos = 9'h0;
        if (pkt != sub_timing_pkg::PKT_LAST)
          pkt++;
        else
        begin
          pkt = 9'h0;
          frm = (frm == wrapVal) ? 4'h0 : frm + 4'h1;
        end
      end
    end
  endtask : tick

  function automatic logic [8:0] adjPos(input logic [8:0] p, input logic [3:0] a);
    int v;
    v = a[3] ? int'(p) + int'(a[2:0]) : int'(p) - int'(a[2:0]) + 288;
    adjPos = 9'(v % 288);
  endfunction : adjPos

  // target two bytes ahead; pos stays low so no packet wrap in between
  task automatic hit(input logic [7:0] m, input logic [8:0] tp, input logic ev, input int expN);
    logic [5:0] tb;
    int         d;
    int         base;
    tb = 6'(pos[8:3] + 6'h2);
    d = int'({tb, 3'h0}) - int'(pos);
    axiWr(8'h14, 8'h20);
    axiWr(8'h18, {tb[4:0], 3'h5});
    axiWr(8'h1c, {7'h0, tb[5]});
    axiWr(8'h20, tp[7:0]);
    axiWr(8'h24, {2'h0, ev, frm, tp[8]});
    axiWr(8'h14, m);
    base = irqCnt;
    tick(d - 1);
    check("irq_early", irqCnt - base, 0);
    tick(1);
    check("irq_hit", irqCnt - base, expN);
    tick(8);
    check("irq_after", irqCnt - base, expN);
    $display("test hit mode %h done", m);
  endtask : hit

  initial
  begin
    seed = 59289;
    rst = 1'h1;
    bitClk = 1'h0;
    blkSync = 1'h0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    wstrb = 4'h1;
    {araddr, arvalid, rready} = '0;
    {errors, samples_checked, cycles, irqCnt} = '0;
    {pos, pkt, frm, wrapVal} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rdChk("mode", 8'h14, 32'h0);
    rdChk("pos_low", 8'h18, 32'h0);
    rdChk("packet", 8'h20, 32'h0);
    rdChk("frame", 8'h24, 32'h0);
    axiRd(8'h40);
    check("unmapped_resp", {30'h0, resp}, {30'h0, sub_timing_pkg::RESP_SLVERR});
    check("unmapped_data", rd, 32'h0);
    axiWr(8'h40, 8'hff);
    check("unmapped_bresp", {30'h0, resp}, {30'h0, sub_timing_pkg::RESP_SLVERR});
    check("irq_idle", {31'h0, irq}, 32'h0);
    $display("test reset done");
    axiWr(8'h14, 8'h10);
    check("mode_bresp", {30'h0, resp}, {30'h0, sub_timing_pkg::RESP_OKAY});
    pkt = 9'($unsigned($random(seed)) % 272);
    frm = 4'($random(seed));
    axiWr(8'h20, pkt[7:0]);
    axiWr(8'h24, {3'h0, frm, pkt[8]});
    rdChk("packet", 8'h20, {24'h0, pkt[7:0]});
    rdChk("frame", 8'h24, {27'h0, frm, pkt[8]});
    wstrb <= 4'h0;
    axiWr(8'h20, ~pkt[7:0]);
    check("nolane_bresp", {30'h0, resp}, {30'h0, sub_timing_pkg::RESP_OKAY});
    wstrb <= 4'h1;
    rdChk("packet_nolane", 8'h20, {24'h0, pkt[7:0]});
    axiWr(8'h14, 8'h00);
    axiWr(8'h20, ~pkt[7:0]);
    rdChk("packet_idle", 8'h20, {24'h0, pkt[7:0]});
    axiWr(8'h14, 8'h20);
    axiWr(8'h20, ~pkt[7:0]);
    rdChk("packet_tgt", 8'h20, {24'h0, pkt[7:0]});
    wrapVal = 4'h2;
    axiWr(8'h14, 8'h30);
    axiWr(8'h24, {3'h0, wrapVal, 1'h1});
    rdChk("frame_max", 8'h24, {27'h0, frm, pkt[8]});
    axiWr(8'h14, 8'h10);
    pkt = sub_timing_pkg::PKT_LAST;
    frm = wrapVal;
    axiWr(8'h20, pkt[7:0]);
    axiWr(8'h24, {3'h0, frm, pkt[8]});
    $display("test load done");
    axiWr(8'h14, 8'h08);
    tick(5 + $unsigned($random(seed)) % 8);
    rdChk("live_low", 8'h18, {24'h0, pos[7:0]});
    rdChk("live_high", 8'h1c, {31'h0, pos[8]});
    tick(288 - int'(pos));
    rdChk("live_wrap", 8'h18, {24'h0, pos[7:0]});
    rdChk("pkt_wrap", 8'h20, {24'h0, pkt[7:0]});
    rdChk("frame_wrap", 8'h24, {27'h0, frm, pkt[8]});
    $display("test wrap done");
    tick(7);
    preSync = pos;
    blkSync <= 1'h1;
    repeat (8) @(posedge clk_sys);
    tick(4);
    axiWr(8'h14, 8'h00);
    rdChk("presync_low", 8'h18, {24'h0, preSync[7:0]});
    rdChk("presync_high", 8'h1c, {31'h0, preSync[8]});
    adj = 4'($random(seed));
    axiWr(8'h28, {4'h0, adj});
    pos = adjPos(pos, adj);
    axiWr(8'h14, 8'h08);
    rdChk("adjusted", 8'h18, {24'h0, pos[7:0]});
    $display("test position done");
    hit(8'h60, pkt, 1'h0, 1);
    hit(8'h20, pkt, 1'h0, 0);
    hit(8'h60, pkt + 9'h3, 1'h1, 1);
    hit(8'h60, pkt + 9'h3, 1'h0, 0);
    blkSync <= 1'h0;
    repeat (8) @(posedge clk_sys);
    hit(8'h60, pkt, 1'h0, 0);
    close_out();
  end
endmodule : subchannel_timing_interrupt_tb_top
`default_nettype wire
